// ==== inc/psu_alert_pkg.sv ====
// Constants and types for the supply alert and address strap logic
package psu_alert_pkg;

   // Event vector positions
   localparam int EVENT_COUNT   = 8;
   localparam int EV_TEMP_WARN  = 0;
   localparam int EV_GEN_FAIL   = 1;
   localparam int EV_OVER_CURR  = 2;
   localparam int EV_OVER_VOLT  = 3;
   localparam int EV_UNDER_VOLT = 4;
   localparam int EV_FAN_FAIL   = 5;
   localparam int EV_END_LIFE   = 6;
   localparam int EV_ENV_LIMIT  = 7;

   // Indicator colour codes
   localparam int            LED_W        = 2;
   localparam logic [LED_W-1:0] LED_CODE_OK = 2'h0;

   // Sense levels in millivolts
   localparam int            MV_W          = 12;
   localparam logic [MV_W-1:0] LOGIC0_MAX_MV = 12'h0320;   // 800 mV
   localparam logic [MV_W-1:0] LOGIC1_MIN_MV = 12'h07D0;   // 2000 mV
   localparam logic [MV_W-1:0] FULL_SCALE_MV = 12'h0CE4;   // 3300 mV
   localparam logic [MV_W-1:0] BAND_BASE_MV  = 12'h0320;   // 800 mV
   localparam logic [MV_W-1:0] BAND_STEP_MV  = 12'h00C8;   // 200 mV

   // Averaging window
   localparam int SAMPLE_COUNT   = 8;
   localparam int SAMPLE_SHIFT   = 3;
   localparam int SAMPLE_IDX_W   = 3;
   localparam int SUM_W          = MV_W + SAMPLE_SHIFT;
   localparam logic [SAMPLE_IDX_W-1:0] SAMPLE_LAST = 3'h7;

   // Sample period timing
   localparam int CLK_PERIOD_NS         = 20;
   localparam int SAMPLE_PERIOD_MIN_NS  = 900000;
   localparam int SAMPLE_PERIOD_MAX_NS  = 1100000;
   localparam int SAMPLE_PERIOD_NOM_NS  = 1000000;
   localparam int SAMPLE_CYCLES         = (SAMPLE_PERIOD_NOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PERIOD_CNT_W          = 17;

   // Address map
   localparam int            NUM_W         = 3;
   localparam logic [7:0]    BUS_ADDR_BASE = 8'hB0;
   localparam logic [7:0]    FRU_ADDR_BASE = 8'hA0;
   localparam logic [NUM_W-1:0] PSU_NUM_MAX = 3'h5;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_DECODE = 2'b11,
      ST_LOCKED = 2'b10
   } addr_state_e;

   typedef enum logic {
      MODE_LOGIC  = 1'b0,
      MODE_ANALOG = 1'b1
   } addr_mode_e;

endpackage : psu_alert_pkg

// ==== inc/sense_avg_if.sv ====
// Link between the address controller and the sense averager
`timescale 1ns/10ps
`default_nettype none
interface sense_avg_if;
   logic                              start;
   logic                              sample_tick;
   logic [psu_alert_pkg::MV_W-1:0]    first_mv;
   logic [psu_alert_pkg::MV_W-1:0]    second_mv;
   logic [psu_alert_pkg::MV_W-1:0]    avg_first;
   logic [psu_alert_pkg::MV_W-1:0]    avg_second;
   logic                              avg_done;

   modport ctrl (output start, output sample_tick, output first_mv, output second_mv,
                 input avg_first, input avg_second, input avg_done);
   modport avg  (input start, input sample_tick, input first_mv, input second_mv,
                 output avg_first, output avg_second, output avg_done);
endinterface : sense_avg_if
`default_nettype wire

// ==== rtl/sense_averager.sv ====
// Eight-sample averager for the two address sense readings
`timescale 1ns/10ps
`default_nettype none
module sense_averager (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Controller side
   sense_avg_if.avg   av
);

   logic [psu_alert_pkg::SUM_W-1:0]        sum_first_reg;
   logic [psu_alert_pkg::SUM_W-1:0]        sum_second_reg;
   logic [psu_alert_pkg::SAMPLE_IDX_W-1:0] idx_reg;
   logic [psu_alert_pkg::SUM_W-1:0]        sum_first_next;
   logic [psu_alert_pkg::SUM_W-1:0]        sum_second_next;

   assign sum_first_next  = sum_first_reg + psu_alert_pkg::SUM_W'(av.first_mv);
   assign sum_second_next = sum_second_reg + psu_alert_pkg::SUM_W'(av.second_mv);

   // Running sums, cleared at window start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sum_first_reg  <= '0;
         sum_second_reg <= '0;
         idx_reg        <= '0;
      end else if (av.start) begin
         sum_first_reg  <= '0;
         sum_second_reg <= '0;
         idx_reg        <= '0;
      end else if (av.sample_tick) begin
         sum_first_reg  <= sum_first_next;
         sum_second_reg <= sum_second_next;
         idx_reg        <= idx_reg + 3'h1;
      end
   end

   // Divide by eight is a plain shift of the final sum
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         av.avg_first  <= '0;
         av.avg_second <= '0;
         av.avg_done   <= 1'b0;
      end else begin
         av.avg_done <= 1'b0;
         if (!av.start && av.sample_tick && idx_reg == psu_alert_pkg::SAMPLE_LAST) begin
            av.avg_first  <= sum_first_next[psu_alert_pkg::SUM_W-1:psu_alert_pkg::SAMPLE_SHIFT];
            av.avg_second <= sum_second_next[psu_alert_pkg::SUM_W-1:psu_alert_pkg::SAMPLE_SHIFT];
            av.avg_done   <= 1'b1;
         end
      end
   end

endmodule : sense_averager
`default_nettype wire

// ==== rtl/psu_address_alert_logic.sv ====
// Supply alert output, input-good output and address strap decoding
`timescale 1ns/10ps
`default_nettype none
module psu_address_alert_logic #(
   parameter int unsigned SAMPLE_CYCLES = psu_alert_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic                                    clk,
   input  wire logic                                    rst,
   // Supply condition events
   input  wire logic [psu_alert_pkg::EVENT_COUNT-1:0]   event_active,
   input  wire logic                                    vin_in_range,
   // Stored configuration
   input  wire logic [psu_alert_pkg::EVENT_COUNT-1:0]   cfg_event_enable,
   input  wire logic [psu_alert_pkg::EVENT_COUNT-1:0]   cfg_event_critical,
   input  wire logic [psu_alert_pkg::LED_W-1:0]         cfg_critical_led,
   input  wire logic [psu_alert_pkg::LED_W-1:0]         cfg_warning_led,
   // Digitised address sense levels in millivolts
   input  wire logic [psu_alert_pkg::MV_W-1:0]          addr_sense_first,
   input  wire logic [psu_alert_pkg::MV_W-1:0]          addr_sense_second,
   // Alert pin, open drain
   output logic                                         fault_alert_n,
   output logic                                         fault_alert_oe,
   output logic [psu_alert_pkg::LED_W-1:0]              led_code,
   output logic                                         alert_critical,
   output logic                                         alert_warning,
   // Input voltage status
   output logic                                         input_voltage_good,
   // Address result
   output logic                                         addr_valid,
   output logic                                         addr_mode_analog,
   output logic [psu_alert_pkg::NUM_W-1:0]              psu_number,
   output logic [7:0]                                   bus_addr,
   output logic [7:0]                                   fru_addr,
   output logic                                         sideband_serial_link
);

   localparam logic [psu_alert_pkg::PERIOD_CNT_W-1:0] PERIOD_LAST =
      psu_alert_pkg::PERIOD_CNT_W'(SAMPLE_CYCLES - 1);

   // Logic level decode of one averaged reading
   function automatic logic level_is_one(input logic [psu_alert_pkg::MV_W-1:0] mv);
      level_is_one = (mv >= psu_alert_pkg::LOGIC1_MIN_MV);
   endfunction : level_is_one

   // Address from base plus twice the supply number
   function automatic logic [7:0] addr_of(input logic [7:0] base,
                                          input logic [psu_alert_pkg::NUM_W-1:0] num);
      addr_of = base + {4'h0, num, 1'b0};
   endfunction : addr_of

   // Analog band index, clipped to the last supply
   function automatic logic [psu_alert_pkg::NUM_W-1:0] band_of(input logic [psu_alert_pkg::MV_W-1:0] mv);
      logic [psu_alert_pkg::MV_W-1:0] off;
      logic [psu_alert_pkg::MV_W-1:0] q;
      off = mv - psu_alert_pkg::BAND_BASE_MV;
      q   = off / psu_alert_pkg::BAND_STEP_MV;
      if (q > psu_alert_pkg::MV_W'(psu_alert_pkg::PSU_NUM_MAX))
         band_of = psu_alert_pkg::PSU_NUM_MAX;
      else
         band_of = q[psu_alert_pkg::NUM_W-1:0];
   endfunction : band_of

   // Alert path
   logic [psu_alert_pkg::EVENT_COUNT-1:0] enabled_events;
   logic                                  any_critical;
   logic                                  any_warning;
   logic [psu_alert_pkg::LED_W-1:0]       led_next;

   // Every listed event, including end of life and environment, goes through the same mask
   assign enabled_events = event_active & cfg_event_enable;
   assign any_critical   = |(enabled_events & cfg_event_critical);
   assign any_warning    = |(enabled_events & ~cfg_event_critical);

   // Critical colour outranks warning colour
   always_comb begin
      if (any_critical)
         led_next = cfg_critical_led;
      else if (any_warning)
         led_next = cfg_warning_led;
      else
         led_next = psu_alert_pkg::LED_CODE_OK;
   end

   // Pin and colour registered together so they move on one edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_alert_n  <= 1'b1;
         fault_alert_oe <= 1'b0;
         led_code       <= psu_alert_pkg::LED_CODE_OK;
         alert_critical <= 1'b0;
         alert_warning  <= 1'b0;
      end else begin
         fault_alert_n  <= !(any_critical | any_warning);
         fault_alert_oe <= any_critical | any_warning;
         led_code       <= led_next;
         alert_critical <= any_critical;
         alert_warning  <= any_warning;
      end
   end

   // Input voltage good
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         input_voltage_good <= 1'b0;
      else
         input_voltage_good <= vin_in_range;
   end

   // Address sensing
   sense_avg_if av ();

   psu_alert_pkg::addr_state_e             state_reg;
   psu_alert_pkg::addr_state_e             state_next;
   logic [psu_alert_pkg::PERIOD_CNT_W-1:0] period_reg;
   logic                                   tick_reg;
   logic [psu_alert_pkg::MV_W-1:0]         avg_first_reg;
   logic [psu_alert_pkg::MV_W-1:0]         avg_second_reg;
   logic                                   first_is_zero;
   logic                                   first_is_one;
   logic                                   analog_sel;
   logic [psu_alert_pkg::NUM_W-1:0]        num_sel;

   sense_averager u_avg (
      .clk (clk),
      .rst (rst),
      .av  (av.avg)
   );

   assign av.start     = (state_reg == psu_alert_pkg::ST_IDLE);
   assign av.sample_tick = tick_reg;
   assign av.first_mv  = addr_sense_first;
   assign av.second_mv = addr_sense_second;

   // Sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         psu_alert_pkg::ST_IDLE:   state_next = psu_alert_pkg::ST_SAMPLE;
         psu_alert_pkg::ST_SAMPLE: if (av.avg_done) state_next = psu_alert_pkg::ST_DECODE;
         psu_alert_pkg::ST_DECODE: state_next = psu_alert_pkg::ST_LOCKED;
         psu_alert_pkg::ST_LOCKED: state_next = psu_alert_pkg::ST_LOCKED;
         default:                  state_next = psu_alert_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         state_reg <= psu_alert_pkg::ST_IDLE;
      else
         state_reg <= state_next;
   end

   // One sample each full period; the first waits a period so the strap can settle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         period_reg <= '0;
         tick_reg   <= 1'b0;
      end else if (state_reg != psu_alert_pkg::ST_SAMPLE) begin
         period_reg <= '0;
         tick_reg   <= 1'b0;
      end else if (period_reg == PERIOD_LAST) begin
         period_reg <= '0;
         tick_reg   <= 1'b1;
      end else begin
         period_reg <= period_reg + 17'h0_0001;
         tick_reg   <= 1'b0;
      end
   end

   // Capture the window result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avg_first_reg  <= '0;
         avg_second_reg <= '0;
      end else if (av.avg_done) begin
         avg_first_reg  <= av.avg_first;
         avg_second_reg <= av.avg_second;
      end
   end

   // Mode choice: the gap between logic ranges is the analog region
   assign first_is_zero = (avg_first_reg <= psu_alert_pkg::LOGIC0_MAX_MV);
   assign first_is_one  = level_is_one(avg_first_reg);
   assign analog_sel    = !first_is_zero && !first_is_one;

   // A second reading in the gap counts as zero; the strap is out of range anyway
   always_comb begin
      if (analog_sel)
         num_sel = band_of(avg_first_reg);
      else
         num_sel = {1'b0, level_is_one(avg_second_reg), first_is_one};
   end

   // Latched once; no address answers before this
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_valid           <= 1'b0;
         addr_mode_analog     <= 1'b0;
         psu_number           <= '0;
         bus_addr             <= '0;
         fru_addr             <= '0;
         sideband_serial_link <= 1'b0;
      end else if (state_reg == psu_alert_pkg::ST_DECODE) begin
         addr_valid           <= 1'b1;
         addr_mode_analog     <= analog_sel;
         psu_number           <= num_sel;
         bus_addr             <= addr_of(psu_alert_pkg::BUS_ADDR_BASE, num_sel);
         fru_addr             <= addr_of(psu_alert_pkg::FRU_ADDR_BASE, num_sel);
         sideband_serial_link <= analog_sel;
      end
   end

endmodule : psu_address_alert_logic
`default_nettype wire

// ==== verification/strap_host_model.sv ====
// Host side: strap levels on the sense inputs and the pull-up on the alert line
`timescale 1ns/10ps
`default_nettype none
module strap_host_model (
   // Clock
   input  wire logic                             clk,
   // Strap levels set by the bench
   input  wire logic [psu_alert_pkg::MV_W-1:0]   first_mv,
   input  wire logic [psu_alert_pkg::MV_W-1:0]   second_mv,
   input  wire logic [psu_alert_pkg::MV_W-1:0]   noise_mv,
   // Block side
   input  wire logic                             fault_alert_n,
   input  wire logic                             fault_alert_oe,
   output logic [psu_alert_pkg::MV_W-1:0]        addr_sense_first,
   output logic [psu_alert_pkg::MV_W-1:0]        addr_sense_second,
   output logic                                  alert_pin
);
   logic       flip_reg  = 1'b0;
   logic [1:0] phase_reg = 2'h0;
   // Sign flips every fourth edge: samples one four-cycle period apart alternate, so only a true average hides it
   always_ff @(posedge clk) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3)
         flip_reg <= ~flip_reg;
   end
   assign addr_sense_first  = flip_reg ? first_mv + noise_mv : first_mv - noise_mv;
   assign addr_sense_second = second_mv;
   // Pull-up wins unless the block sinks the line
   assign alert_pin = fault_alert_oe ? fault_alert_n : 1'b1;
endmodule : strap_host_model
`default_nettype wire

// ==== verification/psu_alert_monitor.sv ====
// Concurrent checks on the alert, input-good and address outputs
`timescale 1ns/10ps
`default_nettype none
module psu_alert_monitor #(
   parameter int unsigned SAMPLE_CYCLES = 4
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Inputs
   input wire logic [7:0] event_active,
   input wire logic       vin_in_range,
   input wire logic [7:0] cfg_event_enable,
   input wire logic [7:0] cfg_event_critical,
   input wire logic [1:0] cfg_critical_led,
   input wire logic [1:0] cfg_warning_led,
   // Outputs
   input wire logic       fault_alert_n,
   input wire logic       fault_alert_oe,
   input wire logic [1:0] led_code,
   input wire logic       alert_critical,
   input wire logic       alert_warning,
   input wire logic       input_voltage_good,
   input wire logic       addr_valid,
   input wire logic       addr_mode_analog,
   input wire logic [2:0] psu_number,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] fru_addr,
   input wire logic       sideband_serial_link
);
   logic        live_reg;
   logic [19:0] age_reg;
   // Keeps $past from looking into the reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) live_reg <= 1'b0;
      else live_reg <= 1'b1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) age_reg <= 20'h0_0000;
      else if (age_reg != 20'hF_FFFF) age_reg <= age_reg + 20'h0_0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_alert_cause: assert property (live_reg |-> fault_alert_oe == $past(|(event_active & cfg_event_enable)))
      else $error("alert enable does not follow enabled events");
   a_warn_class: assert property (live_reg |-> alert_warning == $past(|(event_active & cfg_event_enable & ~cfg_event_critical)))
      else $error("warning flag does not follow warning events");
   a_led_pairs: assert property (live_reg |-> led_code == (alert_critical ? $past(cfg_critical_led) :
      (alert_warning ? $past(cfg_warning_led) : 2'h0))) else $error("colour code does not match alert class");
   a_pin_sinks: assert property (fault_alert_oe |-> !fault_alert_n && (alert_critical || alert_warning))
      else $error("alert line driven without a pending class");
   a_vin_good: assert property (live_reg |-> input_voltage_good == $past(vin_in_range))
      else $error("input good does not follow input range");
   a_addr_sticky: assert property (addr_valid |=> addr_valid && $stable(bus_addr) && $stable(fru_addr))
      else $error("latched address changed");
   a_no_early: assert property (addr_valid |-> age_reg >= 8 * SAMPLE_CYCLES)
      else $error("address ready before eight samples");
   a_window_end: assert property (age_reg == 8 * SAMPLE_CYCLES + 16 |-> addr_valid)
      else $error("address not ready after averaging window");
   a_addr_pair: assert property (addr_valid |-> bus_addr == 8'hB0 + {4'h0, psu_number, 1'b0} &&
      fru_addr == 8'hA0 + {4'h0, psu_number, 1'b0}) else $error("addresses not base plus twice number");
   a_num_range: assert property (addr_valid |-> psu_number <= 3'h5 && (addr_mode_analog || psu_number <= 3'h3))
      else $error("supply number out of range for mode");
   a_side_link: assert property (sideband_serial_link == addr_mode_analog)
      else $error("sideband link not tied to analog mode");
   a_idle_addr: assert property (!addr_valid |-> bus_addr == 8'h00 && fru_addr == 8'h00)
      else $error("address shown before latch");
   c_analog: cover property (addr_valid && addr_mode_analog);
   c_logic: cover property (addr_valid && !addr_mode_analog);
   c_both: cover property (alert_critical && alert_warning);
endmodule : psu_alert_monitor
bind psu_address_alert_logic psu_alert_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_monitor (
   .clk(clk), .rst(rst), .event_active(event_active), .vin_in_range(vin_in_range),
   .cfg_event_enable(cfg_event_enable), .cfg_event_critical(cfg_event_critical),
   .cfg_critical_led(cfg_critical_led), .cfg_warning_led(cfg_warning_led),
   .fault_alert_n(fault_alert_n), .fault_alert_oe(fault_alert_oe), .led_code(led_code),
   .alert_critical(alert_critical), .alert_warning(alert_warning), .input_voltage_good(input_voltage_good),
   .addr_valid(addr_valid), .addr_mode_analog(addr_mode_analog), .psu_number(psu_number),
   .bus_addr(bus_addr), .fru_addr(fru_addr), .sideband_serial_link(sideband_serial_link));
`default_nettype wire

// ==== verification/psu_address_alert_logic_tb_top.sv ====
// Self-checking bench for the alert and address strap block
`timescale 1ns/10ps
`default_nettype none
module psu_address_alert_logic_tb_top;
   localparam int unsigned SC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ev = 8'h00;
   logic vin = 1'b0;
   logic [7:0] en = 8'h00;
   logic [7:0] crit_cfg = 8'h00;
   logic [1:0] crit_led = 2'h3;
   logic [1:0] warn_led = 2'h1;
   logic [11:0] f_mv = 12'h000;
   logic [11:0] s_mv = 12'h000;
   logic [11:0] n_mv = 12'h000;
   logic [11:0] sense_a;
   logic [11:0] sense_b;
   logic fault_alert_n, fault_alert_oe, alert_critical, alert_warning, alert_pin;
   logic input_voltage_good, addr_valid, addr_mode_analog, sideband_serial_link;
   logic [1:0] led_code;
   logic [2:0] psu_number;
   logic [7:0] bus_addr, fru_addr;
   int fail_count = 0;
   int tests_run = 0;

   psu_address_alert_logic #(.SAMPLE_CYCLES(SC)) i_dut (
      .clk(clk), .rst(rst), .event_active(ev), .vin_in_range(vin), .cfg_event_enable(en),
      .cfg_event_critical(crit_cfg), .cfg_critical_led(crit_led), .cfg_warning_led(warn_led),
      .addr_sense_first(sense_a), .addr_sense_second(sense_b), .fault_alert_n(fault_alert_n),
      .fault_alert_oe(fault_alert_oe), .led_code(led_code), .alert_critical(alert_critical),
      .alert_warning(alert_warning), .input_voltage_good(input_voltage_good), .addr_valid(addr_valid),
      .addr_mode_analog(addr_mode_analog), .psu_number(psu_number), .bus_addr(bus_addr),
      .fru_addr(fru_addr), .sideband_serial_link(sideband_serial_link));
   strap_host_model i_host (
      .clk(clk), .first_mv(f_mv), .second_mv(s_mv), .noise_mv(n_mv), .fault_alert_n(fault_alert_n),
      .fault_alert_oe(fault_alert_oe), .addr_sense_first(sense_a), .addr_sense_second(sense_b),
      .alert_pin(alert_pin));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic give_verdict;
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : chk

   // Inputs always move 1 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic do_reset;
      rst = 1'b1;
      step(20);
      rst = 1'b0;
   endtask : do_reset

   task automatic test_alert;
      logic c;
      en = 8'hFF;
      crit_cfg = 8'hAA;
      for (int i = 0; i < 8; i++) begin
         c = crit_cfg[i];
         ev = 8'h01 << i;
         step(1);
         chk(alert_pin === 1'b0 && fault_alert_oe === 1'b1, "alert line not low for event");
         chk(led_code === (c ? 2'h3 : 2'h1), "wrong colour code");
         chk(alert_critical === c && alert_warning === !c, "wrong event class");
         ev = 8'h00;
         step(1);
         chk(alert_pin === 1'b1 && led_code === 2'h0, "alert not released");
      end
      en = 8'hFE;
      ev = 8'h01;
      step(1);
      chk(alert_pin === 1'b1 && alert_warning === 1'b0, "disabled event raised alert");
      en = 8'hFF;
      ev = 8'h03;
      step(1);
      chk(led_code === 2'h3 && alert_warning === 1'b1, "critical colour not preferred");
      crit_led = 2'h2;
      ev = 8'h02;
      step(1);
      chk(led_code === 2'h2 && alert_critical === 1'b1, "colour not taken from configuration");
      crit_led = 2'h3;
      ev = 8'h00;
      vin = 1'b1;
      step(1);
      chk(input_voltage_good === 1'b1, "input good not raised");
      vin = 1'b0;
      step(1);
      chk(input_voltage_good === 1'b0, "input good not dropped");
   endtask : test_alert

   task automatic test_addr(input logic [11:0] a, input logic [11:0] b, input logic [11:0] n,
                            input logic mode, input logic [2:0] num);
      int k;
      f_mv = a;
      s_mv = b;
      n_mv = n;
      do_reset();
      step(1);
      chk(addr_valid === 1'b0 && bus_addr === 8'h00, "address ready too early");
      k = 0;
      while (addr_valid !== 1'b1 && k < 200) begin
         step(1);
         k++;
      end
      chk(addr_valid === 1'b1, "no address after window");
      chk(addr_mode_analog === mode && sideband_serial_link === mode, "wrong addressing mode");
      chk(psu_number === num, "wrong supply number");
      chk(bus_addr === 8'hB0 + {4'h0, num, 1'b0} && fru_addr === 8'hA0 + {4'h0, num, 1'b0}, "wrong addresses");
      f_mv = 12'hCE4;
      s_mv = 12'hCE4;
      step(12 * SC);
      chk(psu_number === num && addr_valid === 1'b1, "address moved after latch");
   endtask : test_addr

   initial begin
      do_reset();
      test_alert();
      test_addr(12'h000, 12'h000, 12'h000, 1'b0, 3'h0);
      test_addr(12'hCE4, 12'h000, 12'h000, 1'b0, 3'h1);
      test_addr(12'h000, 12'hCE4, 12'h000, 1'b0, 3'h2);
      test_addr(12'h960, 12'h960, 12'h000, 1'b0, 3'h3);
      test_addr(12'h320, 12'h7D0, 12'h000, 1'b0, 3'h2);
      test_addr(12'h384, 12'h000, 12'h0C8, 1'b1, 3'h0);
      test_addr(12'h3E8, 12'h000, 12'h000, 1'b1, 3'h1);
      test_addr(12'h514, 12'hCE4, 12'h000, 1'b1, 3'h2);
      test_addr(12'h5DC, 12'h000, 12'h000, 1'b1, 3'h3);
      test_addr(12'h6A4, 12'h000, 12'h000, 1'b1, 3'h4);
      test_addr(12'h76C, 12'h000, 12'h000, 1'b1, 3'h5);
      test_addr(12'h7CF, 12'h000, 12'h000, 1'b1, 3'h5);
      give_verdict();
   end

   // Whole run is near 1300 cycles; this margin only catches a hang
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
endmodule : psu_address_alert_logic_tb_top
`default_nettype wire
